/* hdl/ffa_defs.vh */
// Constants for the fault flag aggregator: register offsets, field positions,
// reset values and limits. Assumes inclusion by bare name from hdl/ files.
`ifndef FFA_DEFS_VH
`define FFA_DEFS_VH

// Register offsets on the serial register port
`define FFA_ADDR_W          8
`define FFA_DATA_W          16
`define FFA_OFS_ANGLE       8'h20
`define FFA_OFS_ERR         8'h24
`define FFA_OFS_WARN        8'h26
`define FFA_OFS_CTRL        8'h28
`define FFA_OFS_ERR_MASK    8'h2a
`define FFA_OFS_WARN_MASK   8'h2c
`define FFA_OFS_CFG         8'h2e

// Error register bit positions
`define FFA_ERR_W           10
`define FFA_ERR_SUPPLY      0
`define FFA_ERR_ANALOG      1
`define FFA_ERR_FIELD_LO    2
`define FFA_ERR_OSC         3
`define FFA_ERR_MEM_UNC     4
`define FFA_ERR_LOCK        5
`define FFA_ERR_ZERO        6
`define FFA_ERR_RESET       7
`define FFA_ERR_QUAD        8
`define FFA_ERR_AVG         9
// Sticky error bits: reset occurred, quadrature, averaging
`define FFA_ERR_STICKY      10'h380
`define FFA_ERR_RESET_VAL   10'h080

// Warning register bit positions
`define FFA_WARN_W          7
`define FFA_WARN_FIELD_HI   0
`define FFA_WARN_TEMP       1
`define FFA_WARN_MEM_COR    2
`define FFA_WARN_TURNS_OV   3
`define FFA_WARN_VELOCITY   4
`define FFA_WARN_IFACE      5
`define FFA_WARN_CHECKSUM   6
// Sticky warning bits: correctable memory, velocity, interface, checksum
`define FFA_WARN_STICKY     7'h74

// Angle register layout
`define FFA_ANG_W           12
`define FFA_ANG_UV          12
`define FFA_ANG_EF          13

// Control register: clear turns overflow and turns count
`define FFA_CTRL_TURNS_CLR  0

// Configuration register fields and reset value
`define FFA_CFG_LO_LSB      0
`define FFA_CFG_LO_MSB      5
`define FFA_CFG_HI_LSB      6
`define FFA_CFG_HI_MSB      11
`define FFA_CFG_RATE_LSB    12
`define FFA_CFG_RATE_MSB    14
`define FFA_CFG_CKSUM_EN    15
`define FFA_CFG_RESET       16'h094d

// Field threshold step shifts (16 G and 32 G steps)
`define FFA_FIELD_W         12
`define FFA_LO_STEP_SH      4
`define FFA_HI_STEP_SH      5

// Angle limits: 135 degrees of a 4096-count turn, quadrant field
`define FFA_VEL_LIMIT       12'h600
`define FFA_QUAD_MSB        11
`define FFA_QUAD_LSB        10
`define FFA_QUAD_LAST       2'h3
`define FFA_QUAD_FIRST      2'h0
`define FFA_QUAD_MAX_SEEN   3'h2

// Turns counter saturation
`define FFA_TURNS_W         10
`define FFA_TURNS_MAX       10'h100
`define FFA_TURNS_MIN       10'h300

// Serial packet lengths in clock edges
`define FFA_EDGE_W          6
`define FFA_PKT16_EDGES     6'h10
`define FFA_PKT20_EDGES     6'h14

// Averaging sample counter width
`define FFA_AVG_CNT_W       8

`endif

/* hdl/ffa_sync.v */
// Input synchroniser for asynchronous detector levels, one lane per bit.
// Assumes levels that stay stable at least two clock periods to be seen.
`timescale 1ns/1ns
module ffa_sync #(
    parameter WIDTH = 8
) (
    input  wire             clock,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
            reg s1_r;
            reg s2_r;
            reg s3_r;
            reg out_r;
            // Three stages; accept a change only once stages two and three agree
            always @(posedge clock or posedge rst) begin
                if (rst) begin
                    s1_r  <= 1'b0;
                    s2_r  <= 1'b0;
                    s3_r  <= 1'b0;
                    out_r <= 1'b0;
                end else begin
                    s1_r <= async_in[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r) begin
                        out_r <= s3_r;
                    end
                end
            end
            assign sync_out[i] = out_r;
        end
    endgenerate

endmodule

/* hdl/ffa_top.v */
// Fault flag aggregator: gathers monitor indications into error, warning
// and angle summary registers read over the serial register port.
// Assumes the serial front end delivers one-cycle read/write strobes on this
// clock and packet reports; analog detectors arrive as asynchronous levels.
//
// Contract
// [R1] Any unmasked flag active sets the general error bit in the angle register.
// [R2] Every status, warning and error flag is readable on the serial register port.
// [R3] Supply low sets its error bit, undervoltage summary and general error.
// [R4] Field above programmable high threshold raises the field-high warning.
// [R5] Field below programmable low threshold raises the field-low error.
// [R6] Temperature outside detectable limits sets the temperature-range warning.
// [R7] Oscillator cross-check discrepancy sets the oscillator fault error bit.
// [R8] Corrected single-bit memory error sets the correctable-memory warning.
// [R9] Multi-bit memory error sets the uncorrectable-memory error bit.
// [R10] Path mismatch, saturation or lock loss set integrity or lock-loss bits.
// [R11] After power loss the reset-occurred error bit is set.
// [R12] A skipped quadrature output state sets the quadrature-integrity error.
// [R13] Analog regulator drift sets its bit, undervoltage summary and general error.
// [R14] Turns count saturating beyond 256 rotations sets the turns-overflow warning.
// [R15] Angle move over 135 degrees between turns updates sets velocity warning.
// [R16] Samples spanning over two quadrants in one averaging period set averaging error.
// [R17] Wrong edge count or leading one in a packet sets the interface warning.
// [R18] Failed checksum on 20-bit packets with checking enabled sets checksum warning.
// [R19] Turns overflow stays set until cleared through the control register.
// [R20] Detector inputs are synchronised; flags update on edges for consistent reads.
`timescale 1ns/1ns
`include "ffa_defs.vh"
module ffa_top #(
    parameter DET_W = 9
) (
    input  wire                    clock,
    input  wire                    rst,
    // Asynchronous detector levels
    input  wire                    supply_low_flag,
    input  wire                    analog_regulator_low,
    input  wire                    temp_out_of_range,
    input  wire                    osc_discrepancy,
    input  wire                    mem_single_corrected,
    input  wire                    mem_multi_detected,
    input  wire                    loop_unlocked,
    input  wire                    zero_crossing_mismatch,
    input  wire                    path_saturated,
    // Same-clock signal path
    input  wire [`FFA_FIELD_W-1:0] field_mag,
    input  wire [`FFA_ANG_W-1:0]   angle_in,
    input  wire                    angle_sample,
    input  wire                    turns_update,
    input  wire                    quad_a,
    input  wire                    quad_b,
    // Serial packet reports
    input  wire                    pkt_done,
    input  wire [`FFA_EDGE_W-1:0]  pkt_edges,
    input  wire                    pkt_msb,
    input  wire                    pkt_crc_ok,
    // Serial register port
    input  wire                    reg_rd,
    input  wire                    reg_wr,
    input  wire [`FFA_ADDR_W-1:0]  reg_addr,
    input  wire [`FFA_DATA_W-1:0]  reg_wdata,
    output reg  [`FFA_DATA_W-1:0]  reg_rdata_r,
    output reg                     reg_rvalid_r,
    output reg                     general_error_flag_r
);

    // Synchronised detector levels
    wire [DET_W-1:0] det_sync;

    ffa_sync #(
        .WIDTH    (DET_W)
    ) u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in ({path_saturated, zero_crossing_mismatch, loop_unlocked,
                    mem_multi_detected, mem_single_corrected, osc_discrepancy,
                    temp_out_of_range, analog_regulator_low, supply_low_flag}),
        .sync_out (det_sync)
    ); // [R20]

    wire s_supply = det_sync[0];
    wire s_analog = det_sync[1];
    wire s_temp   = det_sync[2];
    wire s_osc    = det_sync[3];
    wire s_mcor   = det_sync[4];
    wire s_munc   = det_sync[5];
    wire s_unlock = det_sync[6];
    wire s_zero   = det_sync[7];
    wire s_sat    = det_sync[8];

    // State registers
    reg [`FFA_ERR_W-1:0]   err_r;
    reg [`FFA_ERR_W-1:0]   err_nxt;
    reg [`FFA_WARN_W-1:0]  warn_r;
    reg [`FFA_WARN_W-1:0]  warn_nxt;
    reg [`FFA_ERR_W-1:0]   err_mask_r;
    reg [`FFA_WARN_W-1:0]  warn_mask_r;
    reg [`FFA_DATA_W-1:0]  cfg_r;
    reg [`FFA_ANG_W-1:0]   angle_r;
    reg                    uv_sum_r;
    reg [`FFA_ANG_W-1:0]   turn_angle_r;
    reg [`FFA_TURNS_W-1:0] turns_r;
    reg [`FFA_TURNS_W-1:0] turns_nxt;
    reg [3:0]              quad_seen_r;
    reg [`FFA_AVG_CNT_W-1:0] avg_cnt_r;
    reg [1:0]              quad_prev_r;
    reg                    quad_live_r;

    // Configuration fields
    wire [5:0] thr_lo = cfg_r[`FFA_CFG_LO_MSB:`FFA_CFG_LO_LSB];
    wire [5:0] thr_hi = cfg_r[`FFA_CFG_HI_MSB:`FFA_CFG_HI_LSB];
    wire [2:0] avg_rate = cfg_r[`FFA_CFG_RATE_MSB:`FFA_CFG_RATE_LSB];
    wire       cksum_en = cfg_r[`FFA_CFG_CKSUM_EN];

    // Field limits scaled to gauss; a zero threshold disables the check
    wire [`FFA_FIELD_W-1:0] lim_lo = {2'h0, thr_lo, 4'h0};
    wire [`FFA_FIELD_W-1:0] lim_hi = {1'h0, thr_hi, 5'h00};
    wire field_low  = (thr_lo != 6'h00) && (field_mag < lim_lo); // [R5]
    wire field_high = (thr_hi != 6'h00) && (field_mag > lim_hi); // [R4]

    // Quadrature step check: both lines changing at once is a skipped state
    wire [1:0] quad_now  = {quad_a, quad_b};
    wire       quad_skip = quad_live_r && ((quad_now ^ quad_prev_r) == 2'h3); // [R12]

    // Velocity between turns updates, with wrap-around distance
    wire [`FFA_ANG_W-1:0] ang_delta = angle_in - turn_angle_r;
    wire [`FFA_ANG_W-1:0] ang_dist  = ang_delta[`FFA_ANG_W-1] ?
                                      (~ang_delta + 12'h001) : ang_delta;
    wire vel_excess = turns_update && (ang_dist > `FFA_VEL_LIMIT); // [R15]

    // Full-turn crossings from quadrant transitions at turns updates
    wire [1:0] q_new  = angle_in[`FFA_QUAD_MSB:`FFA_QUAD_LSB];
    wire [1:0] q_old  = turn_angle_r[`FFA_QUAD_MSB:`FFA_QUAD_LSB];
    wire turn_fwd = turns_update && (q_old == `FFA_QUAD_LAST) && (q_new == `FFA_QUAD_FIRST);
    wire turn_rev = turns_update && (q_old == `FFA_QUAD_FIRST) && (q_new == `FFA_QUAD_LAST);
    wire turns_sat_hit = (turn_fwd && (turns_r == `FFA_TURNS_MAX)) ||
                         (turn_rev && (turns_r == `FFA_TURNS_MIN));

    // Averaging period: quadrants seen, period length two to the rate
    wire [3:0] quad_onehot = 4'h1 << angle_in[`FFA_QUAD_MSB:`FFA_QUAD_LSB];
    wire [3:0] seen_nxt    = quad_seen_r | quad_onehot;
    wire [2:0] seen_count  = {2'h0, seen_nxt[0]} + {2'h0, seen_nxt[1]} +
                             {2'h0, seen_nxt[2]} + {2'h0, seen_nxt[3]};
    wire [`FFA_AVG_CNT_W-1:0] avg_last = (8'h01 << avg_rate) - 8'h01;
    wire avg_end   = angle_sample && (avg_cnt_r == avg_last);
    wire avg_fault = avg_end && (seen_count > `FFA_QUAD_MAX_SEEN); // [R16]

    // Packet checks
    wire edges_bad = (pkt_edges != `FFA_PKT16_EDGES) && (pkt_edges != `FFA_PKT20_EDGES);
    wire pkt_iface = pkt_done && (edges_bad || pkt_msb); // [R17]
    wire pkt_cksum = pkt_done && cksum_en && (pkt_edges == `FFA_PKT20_EDGES) &&
                     !pkt_crc_ok; // [R18]

    // Register writes
    wire wr_err   = reg_wr && (reg_addr == `FFA_OFS_ERR);
    wire wr_warn  = reg_wr && (reg_addr == `FFA_OFS_WARN);
    wire wr_ctrl  = reg_wr && (reg_addr == `FFA_OFS_CTRL);
    wire turns_clr = wr_ctrl && reg_wdata[`FFA_CTRL_TURNS_CLR];

    // Next error flags: live bits follow detectors, sticky bits set over clear
    always @* begin
        err_nxt = err_r;
        if (wr_err) begin
            err_nxt = err_r & ~(reg_wdata[`FFA_ERR_W-1:0] & `FFA_ERR_STICKY);
        end
        err_nxt[`FFA_ERR_SUPPLY]   = s_supply;              // [R3]
        err_nxt[`FFA_ERR_ANALOG]   = s_analog;              // [R13]
        err_nxt[`FFA_ERR_FIELD_LO] = field_low;             // [R5]
        err_nxt[`FFA_ERR_OSC]      = s_osc;                 // [R7]
        err_nxt[`FFA_ERR_MEM_UNC]  = s_munc;                // [R9]
        err_nxt[`FFA_ERR_LOCK]     = s_unlock;              // [R10]
        err_nxt[`FFA_ERR_ZERO]     = s_zero | s_sat;        // [R10]
        if (quad_skip) begin
            err_nxt[`FFA_ERR_QUAD] = 1'b1;                  // [R12]
        end
        if (avg_fault) begin
            err_nxt[`FFA_ERR_AVG] = 1'b1;                   // [R16]
        end
    end

    // Next warning flags, same scheme
    always @* begin
        warn_nxt = warn_r;
        if (wr_warn) begin
            warn_nxt = warn_r & ~(reg_wdata[`FFA_WARN_W-1:0] & `FFA_WARN_STICKY);
        end
        if (turns_clr) begin
            warn_nxt[`FFA_WARN_TURNS_OV] = 1'b0;            // [R19]
        end
        warn_nxt[`FFA_WARN_FIELD_HI] = field_high;          // [R4]
        warn_nxt[`FFA_WARN_TEMP]     = s_temp;              // [R6]
        if (s_mcor) begin
            warn_nxt[`FFA_WARN_MEM_COR] = 1'b1;             // [R8]
        end
        if (turns_sat_hit) begin
            warn_nxt[`FFA_WARN_TURNS_OV] = 1'b1;            // [R14]
        end
        if (vel_excess) begin
            warn_nxt[`FFA_WARN_VELOCITY] = 1'b1;            // [R15]
        end
        if (pkt_iface) begin
            warn_nxt[`FFA_WARN_IFACE] = 1'b1;               // [R17]
        end
        if (pkt_cksum) begin
            warn_nxt[`FFA_WARN_CHECKSUM] = 1'b1;            // [R18]
        end
    end

    // Turns count, saturating at both ends, cleared from control
    always @* begin
        turns_nxt = turns_r;
        if (turns_clr) begin
            turns_nxt = {`FFA_TURNS_W{1'b0}};
        end else if (turn_fwd && (turns_r != `FFA_TURNS_MAX)) begin
            turns_nxt = turns_r + 10'h001;
        end else if (turn_rev && (turns_r != `FFA_TURNS_MIN)) begin
            turns_nxt = turns_r - 10'h001;
        end
    end

    // Unmasked summaries computed from next flag values
    wire uv_nxt = (err_nxt[`FFA_ERR_SUPPLY] & ~err_mask_r[`FFA_ERR_SUPPLY]) |
                  (err_nxt[`FFA_ERR_ANALOG] & ~err_mask_r[`FFA_ERR_ANALOG]); // [R3] [R13]
    wire ef_nxt = (|(err_nxt & ~err_mask_r)) | (|(warn_nxt & ~warn_mask_r)); // [R1]

    // Flag, summary and tracking state
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            err_r                <= `FFA_ERR_RESET_VAL; // [R11]
            warn_r               <= {`FFA_WARN_W{1'b0}};
            uv_sum_r             <= 1'b0;
            general_error_flag_r <= 1'b1;
            turns_r              <= {`FFA_TURNS_W{1'b0}};
            turn_angle_r         <= {`FFA_ANG_W{1'b0}};
            angle_r              <= {`FFA_ANG_W{1'b0}};
            quad_prev_r          <= 2'h0;
            quad_live_r          <= 1'b0;
            quad_seen_r          <= 4'h0;
            avg_cnt_r            <= {`FFA_AVG_CNT_W{1'b0}};
        end else begin
            err_r                <= err_nxt;   // [R20]
            warn_r               <= warn_nxt;  // [R20]
            uv_sum_r             <= uv_nxt;
            general_error_flag_r <= ef_nxt;    // [R1]
            turns_r              <= turns_nxt;
            quad_prev_r          <= quad_now;
            quad_live_r          <= 1'b1;
            if (turns_update) begin
                turn_angle_r <= angle_in;
            end
            if (angle_sample) begin
                angle_r <= angle_in;
                if (avg_end) begin
                    quad_seen_r <= 4'h0;
                    avg_cnt_r   <= {`FFA_AVG_CNT_W{1'b0}};
                end else begin
                    quad_seen_r <= seen_nxt;
                    avg_cnt_r   <= avg_cnt_r + 8'h01;
                end
            end
        end
    end

    // Host-writable mask and configuration registers
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            err_mask_r  <= {`FFA_ERR_W{1'b0}};
            warn_mask_r <= {`FFA_WARN_W{1'b0}};
            cfg_r       <= `FFA_CFG_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `FFA_OFS_ERR_MASK) begin
                err_mask_r <= reg_wdata[`FFA_ERR_W-1:0];
            end
            if (reg_addr == `FFA_OFS_WARN_MASK) begin
                warn_mask_r <= reg_wdata[`FFA_WARN_W-1:0];
            end
            if (reg_addr == `FFA_OFS_CFG) begin
                cfg_r <= reg_wdata;
            end
        end
    end

    // Read multiplexer over the registered snapshot
    reg [`FFA_DATA_W-1:0] rd_mux;
    always @* begin
        rd_mux = {`FFA_DATA_W{1'b0}};
        case (reg_addr)
            `FFA_OFS_ANGLE: begin
                rd_mux[`FFA_ANG_W-1:0] = angle_r;
                rd_mux[`FFA_ANG_UV]    = uv_sum_r;
                rd_mux[`FFA_ANG_EF]    = general_error_flag_r;
            end
            `FFA_OFS_ERR: begin
                rd_mux[`FFA_ERR_W-1:0] = err_r;
            end
            `FFA_OFS_WARN: begin
                rd_mux[`FFA_WARN_W-1:0] = warn_r;
            end
            `FFA_OFS_ERR_MASK: begin
                rd_mux[`FFA_ERR_W-1:0] = err_mask_r;
            end
            `FFA_OFS_WARN_MASK: begin
                rd_mux[`FFA_WARN_W-1:0] = warn_mask_r;
            end
            `FFA_OFS_CFG: begin
                rd_mux = cfg_r;
            end
            default: begin
                rd_mux = {`FFA_DATA_W{1'b0}};
            end
        endcase
    end

    // Read answer one cycle after the strobe
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata_r  <= {`FFA_DATA_W{1'b0}};
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_rd;
            if (reg_rd) begin
                reg_rdata_r <= rd_mux; // [R2]
            end
        end
    end

endmodule

/* verification/ffa_properties.sv */
// Checker: register port answer timing and the error summary flag.
// Assumes bind to ffa_top with supply and quadrature masks left clear.
`timescale 1ns/1ns
module ffa_properties (
    input wire        clock,
    input wire        rst,
    input wire        supply_low_flag,
    input wire        quad_a,
    input wire        quad_b,
    input wire        reg_rd,
    input wire [7:0]  reg_addr,
    input wire [15:0] reg_rdata_r,
    input wire        reg_rvalid_r,
    input wire        general_error_flag_r
);
    // One clock domain, reset disables every property
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Named causes; only the supply one spans cycles, the quadrature one matches in one
    sequence angle_read; reg_rd && reg_addr == 8'h20; endsequence
    sequence supply_held; supply_low_flag [*8]; endsequence
    sequence quad_skip; $changed(quad_a) && $changed(quad_b); endsequence
    rd_answer_a: assert property (reg_rd |=> reg_rvalid_r)
        else $error("read got no answer");
    answer_cause_a: assert property (reg_rvalid_r |-> $past(reg_rd))
        else $error("answer without a read");
    rdata_hold_a: assert property (!reg_rvalid_r |-> $stable(reg_rdata_r))
        else $error("read data moved without an answer");
    angle_summary_a: assert property (angle_read |=>
        reg_rdata_r[15:13] == {2'h0, $past(general_error_flag_r)})
        else $error("angle read lost the error summary");
    unmapped_zero_a: assert property (reg_rd && reg_addr == 8'h00 |=>
        reg_rdata_r == 16'h0000) else $error("unmapped read not zero");
    supply_error_a: assert property (supply_held |-> general_error_flag_r)
        else $error("supply low without error summary");
    reset_flag_a: assert property ($fell(rst) |-> general_error_flag_r)
        else $error("no error summary after reset");
    quad_error_a: assert property (quad_skip |-> ##[1:2] general_error_flag_r)
        else $error("skipped state without error summary");
endmodule
bind ffa_top ffa_properties chk (.clock(clock), .rst(rst), .supply_low_flag(supply_low_flag),
    .quad_a(quad_a), .quad_b(quad_b), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r),
    .general_error_flag_r(general_error_flag_r));

/* verification/ffa_host_model.sv */
// Host model: reads and writes flag registers on the register port.
// Assumes ffa_top registers the read answer on the edge that takes the strobe.
`timescale 1ns/1ns
module ffa_host_model (
    input  wire        clock,
    input  wire [15:0] reg_rdata_r,
    input  wire        reg_rvalid_r,
    output reg         reg_rd    = 1'b0,
    output reg         reg_wr    = 1'b0,
    output reg  [7:0]  reg_addr  = 8'h00,
    output reg  [15:0] reg_wdata = 16'h0000
);
    // Read: one-edge strobe; idle address inverted
    task rd(input [7:0] a, output [15:0] d);
        begin
            @(posedge clock);
            reg_rd   <= 1'b1;
            reg_addr <= a;
            @(posedge clock);
            reg_rd   <= 1'b0;
            reg_addr <= ~a;
            #1;
            d = reg_rvalid_r ? reg_rdata_r : 16'hxxxx;
        end
    endtask
    // Write: one-edge strobe; idle lines inverted
    task wr(input [7:0] a, input [15:0] d);
        begin
            @(posedge clock);
            reg_wr    <= 1'b1;
            reg_addr  <= a;
            reg_wdata <= d;
            @(posedge clock);
            reg_wr    <= 1'b0;
            reg_addr  <= ~a;
            reg_wdata <= ~d;
        end
    endtask
endmodule

/* verification/test_ffa_top.sv */
// Bench for ffa_top: detector, path and packet flags read by the host.
// Assumes ffa_host_model on the register port and the bound checker.
`timescale 1ns/1ns
module test_ffa_top;
    reg         clock = 1'b0;
    reg         rst   = 1'b1;
    reg  [8:0]  det   = 9'h000;
    reg  [11:0] field = 12'h258;
    reg  [11:0] angle_and_summary_status   = 12'h000;
    reg         samp  = 1'b0;
    reg         upd   = 1'b0;
    reg         qa    = 1'b0;
    reg         qb    = 1'b0;
    reg         pdone = 1'b0;
    reg  [5:0]  pedge = 6'h10;
    reg  [1:0]  pflag = 2'h1;
    reg  [31:0] seed  = 32'h9aef;
    reg  [15:0] v;
    wire        rd, wr, rv, ef;
    wire [7:0]  addr;
    wire [15:0] wdata, rdata;
    integer     fail_count = 0;
    integer     checked    = 0;
    integer     i, k;
    // Model tables: detector flags, field edges, packets {msb, crc_ok}
    reg  [15:0] de [0:8] = '{16'h1, 16'h2, 16'h0, 16'h8, 16'h0, 16'h10, 16'h20, 16'h40, 16'h40};
    reg  [15:0] dw [0:8] = '{16'h0, 16'h0, 16'h2, 16'h0, 16'h4, 16'h0, 16'h0, 16'h0, 16'h0};
    reg  [11:0] fv [0:3] = '{12'h0cf, 12'h0d0, 12'h4a0, 12'h4a1};
    reg  [5:0]  pe [0:4] = '{6'h11, 6'h10, 6'h14, 6'h14, 6'h10};
    reg  [1:0]  pf [0:4] = '{2'h1, 2'h3, 2'h0, 2'h0, 2'h0};
    reg  [15:0] pw [0:4] = '{16'h20, 16'h20, 16'h0, 16'h40, 16'h0};
    // 20 MHz clock
    always #25 clock = ~clock;
    // Device and host
    ffa_top dut (.clock(clock), .rst(rst), .supply_low_flag(det[0]),
        .analog_regulator_low(det[1]), .temp_out_of_range(det[2]), .osc_discrepancy(det[3]),
        .mem_single_corrected(det[4]), .mem_multi_detected(det[5]), .loop_unlocked(det[6]),
        .zero_crossing_mismatch(det[7]), .path_saturated(det[8]), .field_mag(field),
        .angle_in(angle_and_summary_status), .angle_sample(samp), .turns_update(upd), .quad_a(qa), .quad_b(qb),
        .pkt_done(pdone), .pkt_edges(pedge), .pkt_msb(pflag[1]), .pkt_crc_ok(pflag[0]),
        .reg_rd(rd), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_r(rdata),
        .reg_rvalid_r(rv), .general_error_flag_r(ef));
    ffa_host_model host (.clock(clock), .reg_rdata_r(rdata), .reg_rvalid_r(rv), .reg_rd(rd),
        .reg_wr(wr), .reg_addr(addr), .reg_wdata(wdata));
    // Pseudo-random angles
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Compare and count
    task check(input [15:0] seen, input [15:0] exp, input [7:0] id);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("CHECK FAILED reg %h expected %h seen %h", id, exp, seen);
            end
        end
    endtask
    // Register read against the model
    task rdc(input [7:0] a, input [15:0] exp);
        begin
            host.rd(a, v);
            check(v, exp, a);
        end
    endtask
    // Write-one clear of all sticky flags
    task clr;
        begin
            host.wr(8'h24, 16'h03ff);
            host.wr(8'h26, 16'h007f);
        end
    endtask
    // Angle with a sample (t=0) or turns update (t=1) strobe
    task pulse(input [11:0] a, input t);
        begin
            @(posedge clock);
            angle_and_summary_status  <= a;
            upd  <= t;
            samp <= !t;
            @(posedge clock);
            upd  <= 1'b0;
            samp <= 1'b0;
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", checked, fail_count);
            if (fail_count == 0 && checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // Watchdog, about fifteen-fold margin
    initial begin
        #2000000;
        fail_count = fail_count + 1;
        close_out;
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        rdc(8'h24, 16'h0080);
        rdc(8'h20, 16'h2000);
        check(ef, 1'b1, 8'hef);
        rdc(8'h2e, 16'h094d);
        rdc(8'h2a, 16'h0000);
        rdc(8'h28, 16'h0000);
        rdc(8'h00, 16'h0000);
        host.wr(8'h20, 16'hffff);
        host.wr(8'h24, 16'h0080);
        rdc(8'h24, 16'h0000);
        rdc(8'h20, 16'h0000);
        // Each detector alone, then dropped and cleared
        for (i = 0; i < 9; i = i + 1) begin
            @(posedge clock) det <= 9'h001 << i;
            repeat (10) @(posedge clock);
            rdc(8'h24, de[i]);
            rdc(8'h26, dw[i]);
            rdc(8'h20, {3'h1, i < 2, 12'h000});
            @(posedge clock) det <= 9'h000;
            repeat (10) @(posedge clock);
            clr;
            rdc(8'h24, 16'h0000);
            rdc(8'h26, 16'h0000);
        end
        // Field boundaries at the reset thresholds, then masking
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge clock) field <= fv[i];
            repeat (3) @(posedge clock);
            rdc(8'h24, {15'h0, i == 0} << 2);
            rdc(8'h26, {15'h0, i == 3});
        end
        host.wr(8'h2c, 16'h0001);
        rdc(8'h20, 16'h0000);
        host.wr(8'h2c, 16'h0000);
        rdc(8'h20, 16'h2000);
        @(posedge clock) field <= 12'h258;
        host.wr(8'h2e, 16'h004d);
        rdc(8'h26, 16'h0001);
        host.wr(8'h2e, 16'h094d);
        // Skipped quadrature state, then legal single steps back
        @(posedge clock) qa <= 1'b1;
        qb <= 1'b1;
        repeat (2) @(posedge clock);
        rdc(8'h24, 16'h0100);
        @(posedge clock) qa <= 1'b0;
        @(posedge clock) qb <= 1'b0;
        clr;
        rdc(8'h24, 16'h0000);
        // Packet reports, checksum checking enabled from row 3
        for (i = 0; i < 5; i = i + 1) begin
            if (i == 3)
                host.wr(8'h2e, 16'h894d);
            @(posedge clock) pdone <= 1'b1;
            pedge <= pe[i];
            pflag <= pf[i];
            @(posedge clock) pdone <= 1'b0;
            rdc(8'h26, pw[i]);
            clr;
        end
        // Random angle samples
        for (i = 0; i < 4; i = i + 1) begin
            seed = lfsr(seed);
            pulse(seed[11:0], 1'b0);
            rdc(8'h20, {4'h0, seed[11:0]});
        end
        // Four quadrants in each period of four samples
        host.wr(8'h2e, 16'h294d);
        for (i = 0; i < 8; i = i + 1)
            pulse({i[1:0], 10'h000}, 1'b0);
        rdc(8'h24, 16'h0200);
        clr;
        // Velocity, then turns counted to saturation and one beyond
        pulse(12'h601, 1'b1);
        rdc(8'h26, 16'h0010);
        clr;
        pulse(12'ha00, 1'b1);
        pulse(12'hc00, 1'b1);
        for (k = 0; k < 257; k = k + 1) begin
            if (k == 256)
                rdc(8'h26, 16'h0000);
            for (i = 0; i < 4; i = i + 1)
                pulse({i[1:0], 10'h000}, 1'b1);
        end
        rdc(8'h26, 16'h0008);
        host.wr(8'h26, 16'h0008);
        rdc(8'h26, 16'h0008);
        host.wr(8'h28, 16'h0001);
        rdc(8'h26, 16'h0000);
        // Second reset in mid-run
        @(posedge clock) rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rdc(8'h24, 16'h0080);
        close_out;
    end
endmodule
